/* File: inc/clr_pkg.sv */
// Purpose: Shared types and constants for the compare/logic/rotate datapath
// Assumes: One core clock; one state equals one clock cycle
// Notes: Cost figures are per-instruction base states
`default_nettype none
package clr_pkg;
  localparam int unsigned DW = 32;
  localparam logic [15:0] EXT_ZERO = 16'h0000;
  localparam logic [15:0] EXT_ONES = 16'hFFFF;
  // Bit operand mapping
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [7:0] BIT_SFR_LIMIT = 8'h80;
  localparam logic [15:0] EXT_BIT_LO = 16'h0020;
  localparam logic [15:0] EXT_BIT_HI = 16'h007F;
  // Target masks
  localparam logic [23:0] BLOCK_MASK = 24'hFFF800;
  localparam logic [23:0] REGION_MASK = 24'hFF0000;
  // Base state costs in binary mode; source mode subtracts one from compare costs
  localparam logic [3:0] C_RR_B = 4'h2;
  localparam logic [3:0] C_RR_W = 4'h3;
  localparam logic [3:0] C_RR_D = 4'h5;
  localparam logic [3:0] C_IM_B = 4'h3;
  localparam logic [3:0] C_IM_W = 4'h4;
  localparam logic [3:0] C_IM_D = 4'h6;
  localparam logic [3:0] C_MEM_B = 4'h3;
  localparam logic [3:0] C_MEM_W = 4'h4;
  localparam logic [3:0] C_IND16 = 4'h3;
  localparam logic [3:0] C_IND24 = 4'h4;
  localparam logic [3:0] C_ACC = 4'h1;
  localparam logic [3:0] C_SRC_SAVE = 4'h1;
  localparam logic [3:0] C_IO_ADD = 4'h1;
  localparam logic [3:0] C_SFR_ADD = 4'h2;
  localparam logic [3:0] C_EXT_ADD = 4'h2;

  typedef enum logic [3:0] {
    CLR_OP_CMP = 4'h0, CLR_OP_AND = 4'h1, CLR_OP_OR = 4'h2, CLR_OP_XOR = 4'h3,
    CLR_OP_CLRA = 4'h4, CLR_OP_CPLA = 4'h5, CLR_OP_RL = 4'h6, CLR_OP_RLC = 4'h7,
    CLR_OP_RR = 4'h8, CLR_OP_RRC = 4'h9
  } clr_op_t;
  typedef enum logic [1:0] {CLR_SZ_B = 2'h0, CLR_SZ_W = 2'h1, CLR_SZ_D = 2'h2} clr_size_t;
  typedef enum logic [2:0] {
    CLR_SRC_REG = 3'h0, CLR_SRC_IMM = 3'h1, CLR_SRC_SHORT_DIRECT_OPERAND = 3'h2,
    CLR_SRC_LONG_DIRECT_OPERAND = 3'h3, CLR_SRC_IND16 = 3'h4, CLR_SRC_IND24 = 3'h5
  } clr_src_t;
  typedef enum logic [1:0] {CLR_EXT_NONE = 2'h0, CLR_EXT_ZERO = 2'h1, CLR_EXT_ONES = 2'h2}
    clr_ext_t;
  typedef enum logic [1:0] {CLR_LOC_RAM = 2'h0, CLR_LOC_IO = 2'h1, CLR_LOC_SFR = 2'h2,
    CLR_LOC_EXT = 2'h3} clr_loc_t;

  typedef struct packed {
    clr_op_t op;
    clr_size_t size;
    clr_src_t src;
    clr_ext_t ext;
    clr_loc_t loc;
    logic [1:0] short_inc;
    logic source_mode;
    logic [31:0] dst;
    logic [31:0] srcv;
    logic [15:0] imm16;
  } clr_req_t;

  typedef struct packed {
    logic [31:0] result;
    logic write_back;
    logic carry;
    logic zero;
    logic sign;
  } clr_res_t;

  typedef struct packed {
    logic [23:0] block_addr;
    logic [23:0] region_addr;
    logic [23:0] full_addr;
    logic [23:0] rel_addr;
    logic [7:0] bit_byte;
    logic [2:0] bit_pos;
    logic bit_is_sfr;
    logic ext_bit_ok;
    logic [2:0] short_val;
  } clr_addr_t;
endpackage : clr_pkg
`default_nettype wire

/* File: logic/clr_cost.sv */
// Purpose: State cost of one instruction
// Assumes: Wait-state count is quasi-static configuration
// Notes: Pure combinational
`default_nettype none
module clr_cost (
  input wire clr_pkg::clr_req_t req,
  input wire logic [3:0] wait_n,
  output logic [7:0] states
);
  import clr_pkg::*;
  logic [7:0] base;
  logic [7:0] add;
  always_comb begin
    base = 8'h00;
    add = 8'h00;
    if (req.op == CLR_OP_CMP) begin
      case (req.src)
        CLR_SRC_REG: base = {4'h0, (req.size == CLR_SZ_B) ? C_RR_B :
          (req.size == CLR_SZ_W) ? C_RR_W : C_RR_D};
        CLR_SRC_IMM: base = {4'h0, (req.size == CLR_SZ_B) ? C_IM_B :
          (req.size == CLR_SZ_W) ? C_IM_W : C_IM_D};
        CLR_SRC_IND16: base = {4'h0, C_IND16};
        CLR_SRC_IND24: base = {4'h0, C_IND24};
        default: base = {4'h0, (req.size == CLR_SZ_B) ? C_MEM_B : C_MEM_W};
      endcase
      if (req.source_mode) begin
        base = base - {4'h0, C_SRC_SAVE};
      end
      if (req.src == CLR_SRC_SHORT_DIRECT_OPERAND && req.loc == CLR_LOC_IO) begin
        add = {4'h0, C_IO_ADD};
      end else if (req.src == CLR_SRC_SHORT_DIRECT_OPERAND && req.loc == CLR_LOC_SFR) begin
        add = {4'h0, C_SFR_ADD};
      end else if (req.src >= CLR_SRC_LONG_DIRECT_OPERAND && req.loc == CLR_LOC_EXT) begin
        add = {4'h0, wait_n} + {4'h0, C_EXT_ADD};
        if (req.size == CLR_SZ_W) begin
          add = {add[6:0], 1'b0};
        end
      end
    end else if (req.op >= CLR_OP_CLRA) begin
      base = {4'h0, C_ACC};
    end else begin
      base = {4'h0, C_ACC};
    end
    states = base + add;
  end
endmodule : clr_cost
`default_nettype wire

/* File: logic/clr_addr.sv */
// Purpose: Operand and target address forming
// Assumes: pc_next is the first byte of the following instruction
// Notes: Pure combinational
`default_nettype none
module clr_addr (
  input wire logic [23:0] pc_next,
  input wire logic [7:0] rel8,
  input wire logic [23:0] target,
  input wire logic [7:0] bit_num,
  input wire logic [15:0] ext_bit_addr,
  input wire logic [1:0] short_code,
  output clr_pkg::clr_addr_t addr
);
  import clr_pkg::*;
  always_comb begin
    addr.rel_addr = pc_next + {{16{rel8[7]}}, rel8};
    addr.block_addr = (pc_next & BLOCK_MASK) | (target & ~BLOCK_MASK);
    addr.region_addr = (pc_next & REGION_MASK) | (target & ~REGION_MASK);
    addr.full_addr = target;
    addr.bit_is_sfr = (bit_num >= BIT_SFR_LIMIT);
    addr.bit_pos = bit_num[2:0];
    if (addr.bit_is_sfr) begin
      addr.bit_byte = {bit_num[7:3], 3'h0};
    end else begin
      addr.bit_byte = BIT_RAM_BASE + {4'h0, bit_num[6:3]};
    end
    addr.ext_bit_ok = (ext_bit_addr >= EXT_BIT_LO) && (ext_bit_addr <= EXT_BIT_HI);
    case (short_code)
      2'h0: addr.short_val = 3'h1;
      2'h1: addr.short_val = 3'h2;
      default: addr.short_val = 3'h4;
    endcase
  end
endmodule : clr_addr
`default_nettype wire

/* File: logic/clr_exec.sv */
// Purpose: Compare, logic and accumulator rotate datapath
// Assumes: Requests come from same-clock decode logic; one at a time
// Notes: Busy for all but the last of the instruction's states; done pulses in the last one
// What this block does
// - Accept a 16-bit immediate source operand
// - Extend 16-bit immediate with zeros or ones
// - Short immediate is 1, 2 or 4
// - Bits 00h-7Fh map RAM bytes 20h-2Fh
// - Bits 80h-FFh map SFRs ending 0h/8h
// - Extended bit reaches 0020h-007Fh only
// - Relative target: signed 8-bit from next
// - 11-bit target within same 2-Kbyte block
// - 16-bit target within same 64-Kbyte region
// - 24-bit target reaches whole address space
// - Register compare costs 2/3/5, source 1/2/4
// - Immediate compare costs 3/4/6, source one less
// - Memory compare base costs, source one less
// - I/O port adds 1, SFR adds 2
// - External byte access adds N+2 states
// - External word access adds 2(N+2) states
// - AND/OR/XOR result written to destination
// - Clear loads zero, complement inverts accumulator
// - Rotate left, carry untouched
// - Rotate left through carry
// - Rotate right, carry untouched
// - Rotate right through carry
// - Accumulator ops take one state
`default_nettype none
module clr_exec (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic req_valid,
  input wire clr_pkg::clr_req_t req,
  input wire logic [3:0] wait_n,
  input wire logic carry_in,
  input wire logic [23:0] pc_next,
  input wire logic [7:0] rel8,
  input wire logic [23:0] target,
  input wire logic [7:0] bit_num,
  input wire logic [15:0] ext_bit_addr,
  output logic busy,
  output logic done,
  output clr_pkg::clr_res_t res,
  output clr_pkg::clr_addr_t addr_q,
  output logic [7:0] states_q
);
  import clr_pkg::*;

  typedef enum logic [1:0] {CLR_ST_IDLE = 2'b01, CLR_ST_RUN = 2'b10} clr_state_t;

  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  logic [7:0] states;
  clr_addr_t addr;
  clr_cost u_cost (
    .req(req),
    .wait_n(wait_n),
    .states(states)
  );
  clr_addr u_addr (
    .pc_next(pc_next),
    .rel8(rel8),
    .target(target),
    .bit_num(bit_num),
    .ext_bit_addr(ext_bit_addr),
    .short_code(req.short_inc),
    .addr(addr)
  );

  // Source operand forming
  logic [31:0] srcop;
  always_comb begin
    if (req.src == CLR_SRC_IMM) begin
      case (req.ext)
        CLR_EXT_ZERO: srcop = {EXT_ZERO, req.imm16};
        CLR_EXT_ONES: srcop = {EXT_ONES, req.imm16};
        default: srcop = {16'h0000, req.imm16};
      endcase
    end else begin
      srcop = req.srcv;
    end
  end

  // Result computation
  clr_res_t calc;
  logic [32:0] diff;
  logic [7:0] acc;
  always_comb begin
    acc = req.dst[7:0];
    diff = 33'h000000000;
    calc.result = req.dst;
    calc.write_back = 1'b1;
    calc.carry = carry_in;
    calc.zero = 1'b0;
    calc.sign = 1'b0;
    case (req.op)
      CLR_OP_CMP: begin
        diff = {1'b0, req.dst} - {1'b0, srcop};
        calc.write_back = 1'b0;
        case (req.size)
          CLR_SZ_B: begin
            calc.carry = req.dst[7:0] < srcop[7:0];
            calc.zero = diff[7:0] == 8'h00;
            calc.sign = diff[7];
          end
          CLR_SZ_W: begin
            calc.carry = req.dst[15:0] < srcop[15:0];
            calc.zero = diff[15:0] == 16'h0000;
            calc.sign = diff[15];
          end
          default: begin
            calc.carry = diff[32];
            calc.zero = diff[31:0] == 32'h00000000;
            calc.sign = diff[31];
          end
        endcase
      end
      CLR_OP_AND: calc.result = req.dst & srcop;
      CLR_OP_OR: calc.result = req.dst | srcop;
      CLR_OP_XOR: calc.result = req.dst ^ srcop;
      CLR_OP_CLRA: calc.result = {req.dst[31:8], 8'h00};
      CLR_OP_CPLA: calc.result = {req.dst[31:8], ~acc};
      CLR_OP_RL: calc.result = {req.dst[31:8], acc[6:0], acc[7]};
      CLR_OP_RLC: begin
        calc.result = {req.dst[31:8], acc[6:0], carry_in};
        calc.carry = acc[7];
      end
      CLR_OP_RR: calc.result = {req.dst[31:8], acc[0], acc[7:1]};
      CLR_OP_RRC: begin
        calc.result = {req.dst[31:8], carry_in, acc[7:1]};
        calc.carry = acc[0];
      end
      default: calc.write_back = 1'b0;
    endcase
  end

  // Sequencer: counts the instruction's states before reporting
  clr_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic busy_d, done_d;
  clr_res_t res_d;
  clr_addr_t addr_d;
  logic [7:0] states_d;
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    busy_d = busy;
    done_d = 1'b0;
    res_d = res;
    addr_d = addr_q;
    states_d = states_q;
    case (state_q)
      CLR_ST_IDLE: begin
        if (req_valid) begin
          res_d = calc;
          addr_d = addr;
          states_d = states;
          if (states <= 8'h01) begin
            done_d = 1'b1;
            busy_d = 1'b0;
          end else begin
            cnt_d = states - 8'h02;
            busy_d = 1'b1;
            state_d = CLR_ST_RUN;
          end
        end
      end
      CLR_ST_RUN: begin
        if (cnt_q == 8'h00) begin
          done_d = 1'b1;
          busy_d = 1'b0;
          state_d = CLR_ST_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        state_d = CLR_ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  // Clock enable low freezes everything but the reset synchronizer
  always_ff @(posedge clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      state_q <= CLR_ST_IDLE;
      cnt_q <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      res <= '0;
      addr_q <= '0;
      states_q <= 8'h00;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      busy <= busy_d;
      done <= done_d;
      res <= res_d;
      addr_q <= addr_d;
      states_q <= states_d;
    end
  end
endmodule : clr_exec
`default_nettype wire

/* File: bench/clr_exec_monitor.sv */
// Purpose: Port-level checks for the compare/logic/rotate datapath
// Assumes: Requests arrive only once the design is out of reset
// Notes: A small counter tracks states since the last take
`default_nettype none
module clr_exec_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic req_valid,
  input wire clr_pkg::clr_req_t req,
  input wire logic carry_in,
  input wire logic [23:0] pc_next,
  input wire logic [7:0] rel8,
  input wire logic [23:0] target,
  input wire logic busy,
  input wire logic done,
  input wire clr_pkg::clr_res_t res,
  input wire clr_pkg::clr_addr_t addr_q,
  input wire logic [7:0] states_q
);
  timeunit 1ns;
  timeprecision 1ps;
  import clr_pkg::*;
  logic take;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  assign take = ce && req_valid && !busy;
  // Frozen cycles are not counted, matching the clock enable
  always_comb begin
    cnt_d = cnt_q;
    if (take) cnt_d = 8'h01;
    else if (ce) cnt_d = cnt_q + 8'h01;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 8'h00;
    else cnt_q <= cnt_d;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  chk_acc_single: assert property (take && req.op >= CLR_OP_CLRA |=>
    done && !busy && states_q == 8'h01) else $error("acc op not one state");
  chk_rot_left: assert property (take && req.op == CLR_OP_RL |=>
    res.result[7:0] == {$past(req.dst[6:0]), $past(req.dst[7])} &&
    res.carry == $past(carry_in)) else $error("rotate left wrong");
  chk_rot_lcarry: assert property (take && req.op == CLR_OP_RLC |=>
    {res.carry, res.result[7:0]} == {$past(req.dst[7:0]), $past(carry_in)})
    else $error("rotate left carry wrong");
  chk_rot_right: assert property (take && req.op == CLR_OP_RR |=>
    res.result[7:0] == {$past(req.dst[0]), $past(req.dst[7:1])} &&
    res.carry == $past(carry_in)) else $error("rotate right wrong");
  chk_rot_rcarry: assert property (take && req.op == CLR_OP_RRC |=>
    {res.result[7:0], res.carry} == {$past(carry_in), $past(req.dst[7:0])})
    else $error("rotate right carry wrong");
  chk_acc_invert: assert property (take && req.op == CLR_OP_CPLA |=>
    res.result[7:0] == ~$past(req.dst[7:0])) else $error("complement wrong");
  chk_cmp_discard: assert property (take && req.op == CLR_OP_CMP |=>
    !res.write_back && busy == (states_q > 8'h01)) else $error("compare wrote back");
  chk_done_count: assert property (done && $past(busy) |->
    cnt_q == states_q) else $error("done not at cost count");
  chk_target_form: assert property (take |=>
    addr_q.rel_addr == $past(pc_next) + 24'(signed'($past(rel8))) &&
    addr_q.block_addr == {$past(pc_next[23:11]), $past(target[10:0])})
    else $error("target forming wrong");
endmodule : clr_exec_monitor
bind clr_exec clr_exec_monitor clr_exec_monitor_inst (.clk, .rst_n, .ce, .req_valid, .req,
  .carry_in, .pc_next, .rel8, .target, .busy, .done, .res, .addr_q, .states_q);
`default_nettype wire

/* File: bench/tb_clr_exec.sv */
// Purpose: Self-checking bench for the compare/logic/rotate datapath
// Assumes: Inputs change on the falling clock edge only
// Notes: Rotate bit moves are also judged by the bound checker
`default_nettype none
module tb_clr_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import clr_pkg::*;
  logic clk;
  logic rst_n;
  logic ce;
  logic req_valid;
  logic carry_in;
  logic [3:0] wait_n;
  logic [23:0] pc_next;
  logic [7:0] rel8;
  logic [23:0] target;
  logic [7:0] bit_num;
  logic [15:0] ext_bit_addr;
  clr_req_t req;
  logic busy;
  logic done;
  clr_res_t res;
  clr_addr_t addr_q;
  logic [7:0] states_q;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  `define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  clr_exec clr_exec_inst (.clk, .rst_n, .ce, .req_valid, .req, .wait_n, .carry_in, .pc_next,
    .rel8, .target, .bit_num, .ext_bit_addr, .busy, .done, .res, .addr_q, .states_q);
  task automatic close_out;
    if (fails == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out
  function automatic clr_req_t mk(clr_op_t op, clr_size_t sz = CLR_SZ_B,
      clr_src_t s = CLR_SRC_REG, clr_ext_t x = CLR_EXT_NONE, clr_loc_t l = CLR_LOC_RAM,
      logic sm = 1'b0, logic [31:0] d = 32'h0, logic [31:0] v = 32'h0, logic [1:0] k = 2'h0);
    mk = '{op: op, size: sz, src: s, ext: x, loc: l, short_inc: k, source_mode: sm,
      dst: d, srcv: v, imm16: v[15:0]};
  endfunction : mk
  // One request; fz cycles of clock-enable low right after the take
  task automatic run(input clr_req_t r, input logic [7:0] e, input string nm, input int fz = 0);
    int n;
    @(negedge clk);
    req = r;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    ce = (fz == 0);
    n = 1;
    while (done !== 1'b1 && n < 64) begin
      @(negedge clk);
      n++;
      if (n == fz + 1) ce = 1'b1;
    end
    `CHK(nm, e + fz, n)
    `CHK(nm, e, states_q)
  endtask : run
  task automatic t_cmp;
    for (int m = 0; m < 2; m++) begin
      run(mk(CLR_OP_CMP, CLR_SZ_B, .sm(m[0])), 8'(2 - m), "rr_b");
      run(mk(CLR_OP_CMP, CLR_SZ_W, .sm(m[0])), 8'(3 - m), "rr_w");
      run(mk(CLR_OP_CMP, CLR_SZ_D, .sm(m[0])), 8'(5 - m), "rr_d");
      run(mk(CLR_OP_CMP, CLR_SZ_B, CLR_SRC_IMM, .sm(m[0])), 8'(3 - m), "im_b");
      run(mk(CLR_OP_CMP, CLR_SZ_W, CLR_SRC_IMM, .sm(m[0])), 8'(4 - m), "im_w");
      run(mk(CLR_OP_CMP, CLR_SZ_D, CLR_SRC_IMM, CLR_EXT_ONES, .sm(m[0])),
        8'(6 - m), "im_d");
      run(mk(CLR_OP_CMP, CLR_SZ_D, CLR_SRC_IMM, CLR_EXT_ZERO, .sm(m[0])),
        8'(6 - m), "im_dz");
      run(mk(CLR_OP_CMP, CLR_SZ_W, CLR_SRC_SHORT_DIRECT_OPERAND, .sm(m[0])), 8'(4 - m), "d8_w");
      run(mk(CLR_OP_CMP, CLR_SZ_B, CLR_SRC_LONG_DIRECT_OPERAND, .sm(m[0])), 8'(3 - m), "d16_b");
      run(mk(CLR_OP_CMP, CLR_SZ_B, CLR_SRC_IND16, .sm(m[0])), 8'(3 - m), "i16_b");
      run(mk(CLR_OP_CMP, CLR_SZ_B, CLR_SRC_IND24, .sm(m[0])), 8'(4 - m), "i24_b");
    end
    run(mk(CLR_OP_CMP, CLR_SZ_B, CLR_SRC_SHORT_DIRECT_OPERAND, CLR_EXT_NONE, CLR_LOC_IO),
      8'h04, "io");
    run(mk(CLR_OP_CMP, CLR_SZ_B, CLR_SRC_SHORT_DIRECT_OPERAND, CLR_EXT_NONE, CLR_LOC_SFR),
      8'h05, "sfr");
    run(mk(CLR_OP_CMP, CLR_SZ_B, CLR_SRC_SHORT_DIRECT_OPERAND, CLR_EXT_NONE, CLR_LOC_SFR, 1'b1),
      8'h04, "sfr_s");
    run(mk(CLR_OP_CMP, CLR_SZ_B, CLR_SRC_LONG_DIRECT_OPERAND, CLR_EXT_NONE, CLR_LOC_EXT),
      8'h08, "xb");
    wait_n = 4'hF;
    run(mk(CLR_OP_CMP, CLR_SZ_W, CLR_SRC_LONG_DIRECT_OPERAND, CLR_EXT_NONE, CLR_LOC_EXT),
      8'h26, "xw", 2);
    run(mk(CLR_OP_CMP, CLR_SZ_B, CLR_SRC_IND16, CLR_EXT_NONE, CLR_LOC_EXT),
      8'h14, "i16_x");
    run(mk(CLR_OP_CMP, .d(32'h10), .v(32'h20)), 8'h02, "lt");
    `CHK("lt_flags", 4'h5, {res.write_back, res.carry, res.zero, res.sign})
    run(mk(CLR_OP_CMP, CLR_SZ_W, .d(32'h8001), .v(32'h8001)), 8'h03, "eq");
    `CHK("eq_flags", 4'h2, {res.write_back, res.carry, res.zero, res.sign})
    run(mk(CLR_OP_CMP, CLR_SZ_W, CLR_SRC_IMM, .d(32'h1233), .v(32'h1234)), 8'h04, "im16");
    `CHK("im16_flags", 4'h5, {res.write_back, res.carry, res.zero, res.sign})
    run(mk(CLR_OP_CMP, CLR_SZ_D, CLR_SRC_IMM, CLR_EXT_ZERO, .d(32'h1234), .v(32'h1234)),
      8'h06, "zx");
    `CHK("zx_flags", 4'h2, {res.write_back, res.carry, res.zero, res.sign})
    run(mk(CLR_OP_CMP, CLR_SZ_D, CLR_SRC_IMM, CLR_EXT_ONES, .d(32'h1234), .v(32'h1234)),
      8'h06, "ox");
    `CHK("ox_flags", 4'h4, {res.write_back, res.carry, res.zero, res.sign})
  endtask : t_cmp
  task automatic t_logic;
    run(mk(CLR_OP_AND, CLR_SZ_W, .d(32'hF0F0), .v(32'h3C5A)), 8'h01, "and");
    `CHK("and_res", 17'h13050, {res.write_back, res.result[15:0]})
    run(mk(CLR_OP_OR, CLR_SZ_W, .d(32'hF0F0), .v(32'h3C5A)), 8'h01, "or");
    `CHK("or_res", 17'h1FCFA, {res.write_back, res.result[15:0]})
    run(mk(CLR_OP_XOR, CLR_SZ_W, .d(32'hF0F0), .v(32'h3C5A)), 8'h01, "xor");
    `CHK("xor_res", 17'h1CCAA, {res.write_back, res.result[15:0]})
  endtask : t_logic
  task automatic t_acc;
    carry_in = 1'b1;
    run(mk(CLR_OP_CLRA, .d(32'hA5)), 8'h01, "clr");
    `CHK("clr_res", 8'h00, res.result[7:0])
    run(mk(CLR_OP_CPLA, .d(32'h5A)), 8'h01, "cpl");
    `CHK("cpl_res", 8'hA5, res.result[7:0])
    run(mk(CLR_OP_RL, .d(32'h81)), 8'h01, "rl");
    `CHK("rl_res", 9'h103, {res.carry, res.result[7:0]})
    run(mk(CLR_OP_RLC, .d(32'h5A)), 8'h01, "rlc");
    `CHK("rlc_res", 9'h0B5, {res.carry, res.result[7:0]})
    run(mk(CLR_OP_RR, .d(32'h81)), 8'h01, "rr");
    `CHK("rr_res", 9'h1C0, {res.carry, res.result[7:0]})
    run(mk(CLR_OP_RRC, .d(32'h5A)), 8'h01, "rrc");
    `CHK("rrc_res", 9'h0AD, {res.carry, res.result[7:0]})
  endtask : t_acc
  task automatic chk_addr(input string nm, input logic [23:0] b, input logic [23:0] g,
      input logic [23:0] f, input logic [23:0] l, input logic [15:0] bt);
    `CHK(nm, b, addr_q.block_addr)
    `CHK(nm, g, addr_q.region_addr)
    `CHK(nm, f, addr_q.full_addr)
    `CHK(nm, l, addr_q.rel_addr)
    `CHK(nm, bt, addr_q[15:0])
  endtask : chk_addr
  task automatic t_addr;
    run(mk(CLR_OP_RL, .k(2'h2)), 8'h01, "adr_a");
    chk_addr("adr_a", 24'h1235EF, 24'h12CDEF, 24'hABCDEF, 24'h1233D6,
      {8'h90, 3'h3, 1'h1, 1'h1, 3'h4});
    rel8 = 8'h7F;
    target = 24'h000000;
    bit_num = 8'h7F;
    ext_bit_addr = 16'h007F;
    run(mk(CLR_OP_RR), 8'h01, "adr_b");
    chk_addr("adr_b", 24'h123000, 24'h120000, 24'h000000, 24'h1234D5,
      {8'h2F, 3'h7, 1'h0, 1'h1, 3'h1});
    pc_next = 24'h7007FE;
    rel8 = 8'h05;
    target = 24'hFFFFFF;
    bit_num = 8'h80;
    ext_bit_addr = 16'h0080;
    run(mk(CLR_OP_RR, .k(2'h1)), 8'h01, "adr_c");
    chk_addr("adr_c", 24'h7007FF, 24'h70FFFF, 24'hFFFFFF, 24'h700803,
      {8'h80, 3'h0, 1'h1, 1'h0, 3'h2});
  endtask : t_addr
  // Reset while idle must clear the outputs and leave the block usable
  task automatic t_reset;
    @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    `CHK("rst_out", 10'h000, {busy, done, states_q})
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    run(mk(CLR_OP_RL, .d(32'h01)), 8'h01, "rst_rl");
    `CHK("rst_rl_res", 9'h102, {res.carry, res.result[7:0]})
  endtask : t_reset
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out;
    end
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    req_valid = 1'b0;
    carry_in = 1'b0;
    wait_n = 4'h3;
    pc_next = 24'h123456;
    rel8 = 8'h80;
    target = 24'hABCDEF;
    bit_num = 8'h93;
    ext_bit_addr = 16'h0030;
    req = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    t_cmp;
    t_logic;
    t_acc;
    t_addr;
    t_reset;
    close_out;
  end
endmodule : tb_clr_exec
`default_nettype wire
